/* core/ascd_map.svh */
// Opcodes, field codes, masks, counts and reset values of the decoder
`ifndef ASCD_MAP_SVH
`define ASCD_MAP_SVH

// Single-byte opcodes
`define ASCD_OP_WAKE_LO        8'h00
`define ASCD_OP_WAKE_HI        8'hFF
`define ASCD_OP_READ_ONE       8'h01
`define ASCD_OP_READ_CONT      8'h03
`define ASCD_OP_STOP_CONT      8'h0F
`define ASCD_OP_COPY_ALL       8'h48
`define ASCD_OP_ALL_SUM_MASKED 8'hD8
`define ASCD_OP_REG_SUM        8'hDF
`define ASCD_OP_ALL_SUM        8'hE8
`define ASCD_OP_CAL_FIRST      8'hF0
`define ASCD_OP_CAL_LAST       8'hF4
`define ASCD_OP_SYNC           8'hFC
`define ASCD_OP_SLEEP          8'hFD
`define ASCD_OP_RESET          8'hFE

// Upper nibble of the register read/write and masked sum commands
`define ASCD_NIB_REG_READ      4'h1
`define ASCD_NIB_REG_WRITE     4'h5
`define ASCD_NIB_SUM_MASKED    4'hD

// Upper five bits of the bank commands (bank in the low three)
`define ASCD_HI5_BANK_READ     5'h04
`define ASCD_HI5_BANK_WRITE    5'h0C
`define ASCD_HI5_COPY_TO_BANK  5'h08
`define ASCD_HI5_COPY_FROM     5'h18
`define ASCD_HI5_SUM_MASKED    5'h1A
`define ASCD_HI5_SUM           5'h1C

// Walk limits and counters
`define ASCD_BANK_LAST         7'h0F
`define ASCD_RAM_LAST          7'h7F
`define ASCD_RES_LAST          2'h2
`define ASCD_BIT_FIRST         3'h0
`define ASCD_BIT_LAST          3'h7

// Register defaults and checksum masks
`define ASCD_REG_RESET         8'h00
`define ASCD_ID_REG            4'h0
`define ASCD_ID_MASK           8'hF1
`define ASCD_DIO_REG           4'h7
`define ASCD_DIO_MASK          8'hFF
`define ASCD_SYNC_RESET        3'h4

`endif

/* core/ascd_pkg.sv */
// Types shared by the serial command decoder modules
`default_nettype none
package ascd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COUNT,
    ST_REG_RD,
    ST_REG_WR,
    ST_BANK_RD,
    ST_BANK_WR,
    ST_RESULT,
    ST_WALK
  } ascd_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       tgl;
    logic       b0_tgl;
  } ascd_rx_s;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [7:0] tx_cur;
    logic       dout;
  } ascd_frame_s;

  typedef struct packed {
    logic       cal_start;
    logic [2:0] cal_kind;
    logic       conv_sync;
    logic       sleep;
    logic       wake;
    logic       regs_reset;
  } ascd_ctl_s;

  typedef struct packed {
    ascd_state_e        state;
    logic               cont;
    logic               data_ready_n_n;
    logic               busy;
    logic [7:0]         cmd;
    logic [6:0]         addr;
    logic [6:0]         cnt;
    logic [6:0]         idx;
    logic [6:0]         last;
    logic [7:0]         sum;
    logic [1:0]         res_idx;
    logic [23:0]        result;
    logic [7:0]         tx;
    logic               sync_arm;
    logic               rx_seen;
    logic               b0_seen;
    ascd_ctl_s          ctl;
    logic [15:0][7:0]   regs;
    logic [127:0][7:0]  ram;
  } ascd_core_s;

endpackage : ascd_pkg
`default_nettype wire

/* core/ascd_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ascd_sync
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Asynchronous inputs and filtered levels
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] lvl_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] lvl_next;

  // A bit changes only once stages two and three agree
  assign agree    = s2_reg ~^ s3_reg;
  assign lvl_next = (agree & s3_reg) | (~agree & lvl_reg);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s1_reg  <= RESET_VAL;
      s2_reg  <= RESET_VAL;
      s3_reg  <= RESET_VAL;
      lvl_reg <= RESET_VAL;
    end
    else
    begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule : ascd_sync
`default_nettype wire

/* core/ascd_link.sv */
// Serial-clock side: byte shifter for the input and output lines
`timescale 1ns/1ps
`default_nettype none
`include "ascd_map.svh"
module ascd_link
  import ascd_pkg::*;
(
  // Link clock, frame select and reset
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_rst_n,
  // Serial lines
  input  wire logic       i_din,
  output var  logic       o_dout,
  // Byte exchange with the system side
  input  wire logic [7:0] i_tx,
  output var  ascd_rx_s   o_rx
);

  ascd_frame_s frame_reg;
  ascd_frame_s frame_next;
  ascd_rx_s    rx_reg;
  ascd_rx_s    rx_next;

  always_comb
  begin
    frame_next         = frame_reg;
    rx_next            = rx_reg;
    frame_next.bit_cnt = frame_reg.bit_cnt + 3'h1;
    frame_next.shift   = {frame_reg.shift[5:0], i_din};
    // Output byte is taken at the first edge of each byte
    if (frame_reg.bit_cnt == `ASCD_BIT_FIRST)
    begin
      frame_next.tx_cur = i_tx;
      frame_next.dout   = i_tx[7];
      rx_next.b0_tgl    = ~rx_reg.b0_tgl;
    end
    else
    begin
      frame_next.dout =
        frame_reg.tx_cur[3'(`ASCD_BIT_LAST - frame_reg.bit_cnt)];
    end
    if (frame_reg.bit_cnt == `ASCD_BIT_LAST)
    begin
      rx_next.data = {frame_reg.shift, i_din};
      rx_next.tgl  = ~rx_reg.tgl;
    end
  end

  // Frame state ends with the frame itself
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      frame_reg <= '0;
    else
      frame_reg <= frame_next;
  end

  // Toggles survive frames so the system side never sees a false event
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rx_reg <= '0;
    else
      rx_reg <= rx_next;
  end

  assign o_dout = frame_reg.dout;
  assign o_rx   = rx_reg;

endmodule : ascd_link
`default_nettype wire

/* core/ascd_top.sv */
// Serial command decoder of the converter, system clock side
//
// Summary of operation
// R1 - All opcodes are one byte except register and bank read/write with count byte.
// R2 - Host holds chip select low across each whole command sequence.
// R3 - Resume_cmd is 00h or FFh; 01h single read; 03h/0Fh start/stop.
// R4 - Register read 1rh, write 5rh; count byte low nibble.
// R5 - Bank read 2xh, bank write 6xh; seven-bit count byte.
// R6 - Copy regs to bank 4xh, to all banks 48h, bank to regs Cxh.
// R7 - Sums: Dxh, D8h, DFh masked; Exh, E8h unmasked.
// R8 - F0h to F4h start the five calibration kinds in order.
// R9 - FCh arms sync, FDh sleeps, FEh resets registers.
// R10 - Every count is items minus one; one more item moves.
// R11 - Data-ready rises after three result bytes of a single read.
// R12 - Host reads only after data-ready low and waits access delay.
// R13 - Continuous mode presents each new result without new commands.
// R14 - Stop or reset in any result byte ends continuous mode.
// R15 - Host sends stop between data-ready falling and rising.
// R16 - Register read walks up to 16 registers, wrapping at the end.
// R17 - Register write stores count plus one bytes from start register.
// R18 - Bank read crosses banks and wraps to the first bank.
// R19 - Bank write crosses banks and wraps to the first bank.
// R20 - Copy regs into one or all banks; host waits until done.
// R21 - Copy bank into registers overwrites all; host waits.
// R22 - Sums are byte sums, carry dropped, masked bits excluded.
// R23 - Sync fires at the first serial clock of the following byte.
// R24 - Undefined opcodes are ignored; decoder waits for a new byte.
// R25 - Busy is high for the whole copy or checksum walk.
`timescale 1ns/1ps
`default_nettype none
`include "ascd_map.svh"
module ascd_top
  import ascd_pkg::*;
(
  // System clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESET_N,
  // Serial link
  input  wire logic        I_SCLK,
  input  wire logic        I_CS_N,
  input  wire logic        I_DIN,
  output var  logic        O_DOUT,
  // Conversion path
  input  wire logic        I_RESULT_VALID,
  input  wire logic [23:0] I_RESULT,
  output var  logic        O_DATA_READY_N,
  // Status and control towards the converter
  output var  logic        O_BUSY,
  output var  logic        O_CAL_START,
  output var  logic [2:0]  O_CAL_KIND,
  output var  logic        O_CONV_SYNC,
  output var  logic        O_SLEEP,
  output var  logic        O_WAKE,
  output var  logic        O_REGS_RESET
);

  localparam ascd_core_s CORE_RST = '{
    state   : ST_IDLE,
    data_ready_n_n  : 1'b1,
    regs    : {16{`ASCD_REG_RESET}},
    default : '0
  };

  ascd_core_s r;
  ascd_core_s n;
  ascd_rx_s   link_rx;
  logic [2:0] lvl;
  logic       cs_n_s;
  logic       rx_ev;
  logic       b0_ev;
  logic [7:0] b;
  logic       walk_all;
  logic       walk_copy;
  logic       walk_from;
  logic       walk_masked;
  logic [6:0] walk_ram;
  logic [7:0] sum_src;
  logic [7:0] sum_byte;
  logic [3:0] reg_nxt;
  logic [6:0] ram_nxt;
  logic       b_walk;
  logic       b_all;

  function automatic logic [7:0] sum_mask(input logic [3:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a == `ASCD_ID_REG)
      m = `ASCD_ID_MASK;
    else if (a == `ASCD_DIO_REG)
      m = `ASCD_DIO_MASK;
    return m;
  endfunction : sum_mask

  function automatic logic [7:0] res_byte(input logic [23:0] res,
                                          input logic [1:0]  i);
    logic [7:0] v;
    v = res[7:0];
    if (i == 2'h0)
      v = res[23:16];
    else if (i == 2'h1)
      v = res[15:8];
    return v;
  endfunction : res_byte

  ascd_link u_link (
    .i_sclk  (I_SCLK),
    .i_cs_n  (I_CS_N),
    .i_rst_n (I_RESET_N),
    .i_din   (I_DIN),
    .o_dout  (O_DOUT),
    .i_tx    (r.tx),
    .o_rx    (link_rx)
  );

  ascd_sync #(
    .WIDTH     (3),
    .RESET_VAL (`ASCD_SYNC_RESET)
  ) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RESET_N),
    .i_async ({I_CS_N, link_rx.tgl, link_rx.b0_tgl}),
    .o_level (lvl)
  );

  assign cs_n_s = lvl[2];
  assign rx_ev  = lvl[1] != r.rx_seen;
  assign b0_ev  = lvl[0] != r.b0_seen;
  // Byte word is stable: the host leaves a gap before the next byte
  assign b      = link_rx.data;

  // Walk source and destination selection
  assign walk_all    = (r.cmd == `ASCD_OP_COPY_ALL) ||
                       (r.cmd == `ASCD_OP_ALL_SUM_MASKED) ||
                       (r.cmd == `ASCD_OP_ALL_SUM);
  assign walk_copy   = (r.cmd[7:3] == `ASCD_HI5_COPY_TO_BANK) ||
                       (r.cmd == `ASCD_OP_COPY_ALL);
  assign walk_from   = r.cmd[7:3] == `ASCD_HI5_COPY_FROM;
  assign walk_masked = r.cmd[7:4] == `ASCD_NIB_SUM_MASKED;
  assign walk_ram    = walk_all ? r.idx : {r.cmd[2:0], r.idx[3:0]};
  assign sum_src     = (r.cmd == `ASCD_OP_REG_SUM) ? r.regs[r.idx[3:0]]
                                                   : r.ram[walk_ram];
  assign sum_byte    = walk_masked ? (sum_src & ~sum_mask(r.idx[3:0]))
                                   : sum_src; // R22
  assign reg_nxt     = r.addr[3:0] + 4'h1; // R16
  assign ram_nxt     = r.addr + 7'h01;     // R18 R19

  // Opcodes that start a copy or checksum walk
  assign b_walk = (b[7:3] == `ASCD_HI5_COPY_TO_BANK) ||
                  (b == `ASCD_OP_COPY_ALL) ||
                  (b[7:3] == `ASCD_HI5_COPY_FROM) ||
                  (b[7:3] == `ASCD_HI5_SUM_MASKED) ||
                  (b == `ASCD_OP_ALL_SUM_MASKED) ||
                  (b == `ASCD_OP_REG_SUM) ||
                  (b[7:3] == `ASCD_HI5_SUM) ||
                  (b == `ASCD_OP_ALL_SUM); // R6 R7
  assign b_all  = (b == `ASCD_OP_COPY_ALL) ||
                  (b == `ASCD_OP_ALL_SUM_MASKED) ||
                  (b == `ASCD_OP_ALL_SUM);

  always_comb
  begin
    n         = r;
    n.ctl     = '0;
    n.rx_seen = lvl[1];
    n.b0_seen = lvl[0];

    if (b0_ev && r.sync_arm)
    begin
      n.ctl.conv_sync = 1'b1; // R23
      n.sync_arm      = 1'b0;
    end

    // A dropped select abandons an unfinished multi-byte command
    if (cs_n_s && (r.state != ST_WALK))
    begin
      n.state = ST_IDLE; // R2
      if (r.state == ST_RESULT)
        n.res_idx = 2'h0;
    end

    unique case (r.state)
      ST_IDLE:
      begin
        if (rx_ev && r.cont)
        begin
          if ((b == `ASCD_OP_STOP_CONT) || (b == `ASCD_OP_RESET))
          begin
            n.cont = 1'b0; // R14
            if (b == `ASCD_OP_RESET)
            begin
              n.regs           = {16{`ASCD_REG_RESET}};
              n.ctl.regs_reset = 1'b1;
            end
          end
          if (!r.data_ready_n_n)
          begin
            if (r.res_idx == `ASCD_RES_LAST)
            begin
              n.data_ready_n_n  = 1'b1; // R13
              n.res_idx = 2'h0;
            end
            else
              n.res_idx = r.res_idx + 2'h1;
          end
        end
        else if (rx_ev)
        begin
          n.cmd = b; // R1
          if ((b == `ASCD_OP_WAKE_LO) || (b == `ASCD_OP_WAKE_HI))
            n.ctl.wake = 1'b1; // R3
          else if (b == `ASCD_OP_READ_ONE)
          begin
            n.state   = ST_RESULT; // R3
            n.res_idx = 2'h0;
            n.tx      = res_byte(r.result, 2'h0);
          end
          else if (b == `ASCD_OP_READ_CONT)
          begin
            n.cont    = 1'b1; // R3
            n.res_idx = 2'h0;
          end
          else if (b == `ASCD_OP_STOP_CONT)
            n.cont = 1'b0; // R3
          else if ((b[7:4] == `ASCD_NIB_REG_READ) ||
                   (b[7:4] == `ASCD_NIB_REG_WRITE))
          begin
            n.addr  = {3'h0, b[3:0]}; // R4
            n.state = ST_COUNT;
          end
          else if ((b[7:3] == `ASCD_HI5_BANK_READ) ||
                   (b[7:3] == `ASCD_HI5_BANK_WRITE))
          begin
            n.addr  = {b[2:0], 4'h0}; // R5
            n.state = ST_COUNT;
          end
          else if (b_walk)
          begin
            n.state = ST_WALK;
            n.busy  = 1'b1; // R25
            n.idx   = 7'h00;
            n.sum   = 8'h00;
            n.last  = b_all ? `ASCD_RAM_LAST : `ASCD_BANK_LAST; // R20
          end
          else if ((b >= `ASCD_OP_CAL_FIRST) &&
                   (b <= `ASCD_OP_CAL_LAST))
          begin
            n.ctl.cal_start = 1'b1; // R8
            n.ctl.cal_kind  = b[2:0];
            n.data_ready_n_n        = 1'b1;
          end
          else if (b == `ASCD_OP_SYNC)
            n.sync_arm = 1'b1; // R9
          else if (b == `ASCD_OP_SLEEP)
            n.ctl.sleep = 1'b1; // R9
          else if (b == `ASCD_OP_RESET)
          begin
            n.regs           = {16{`ASCD_REG_RESET}}; // R9
            n.ctl.regs_reset = 1'b1;
          end
          else
            n.state = ST_IDLE; // R24
        end
      end

      ST_COUNT:
      begin
        if (rx_ev)
        begin
          unique case (1'b1)
            r.cmd[7:4] == `ASCD_NIB_REG_READ:
            begin
              n.cnt   = {3'h0, b[3:0]}; // R4 R10
              n.state = ST_REG_RD;
              n.tx    = r.regs[r.addr[3:0]];
            end
            r.cmd[7:4] == `ASCD_NIB_REG_WRITE:
            begin
              n.cnt   = {3'h0, b[3:0]}; // R4 R10
              n.state = ST_REG_WR;
            end
            r.cmd[7:3] == `ASCD_HI5_BANK_READ:
            begin
              n.cnt   = b[6:0]; // R5 R10
              n.state = ST_BANK_RD;
              n.tx    = r.ram[r.addr];
            end
            default:
            begin
              n.cnt   = b[6:0]; // R5 R10
              n.state = ST_BANK_WR;
            end
          endcase
        end
      end

      ST_REG_RD, ST_BANK_RD:
      begin
        if (rx_ev)
        begin
          if (r.cnt == 7'h00)
            n.state = ST_IDLE; // R10
          else
          begin
            n.cnt = r.cnt - 7'h01;
            if (r.state == ST_REG_RD)
            begin
              n.addr = {3'h0, reg_nxt}; // R16
              n.tx   = r.regs[reg_nxt];
            end
            else
            begin
              n.addr = ram_nxt; // R18
              n.tx   = r.ram[ram_nxt];
            end
          end
        end
      end

      ST_REG_WR, ST_BANK_WR:
      begin
        if (rx_ev)
        begin
          if (r.state == ST_REG_WR)
          begin
            n.regs[r.addr[3:0]] = b; // R17
            n.addr              = {3'h0, reg_nxt};
          end
          else
          begin
            n.ram[r.addr] = b; // R19
            n.addr        = ram_nxt;
          end
          if (r.cnt == 7'h00)
            n.state = ST_IDLE; // R10
          else
            n.cnt = r.cnt - 7'h01;
        end
      end

      ST_RESULT:
      begin
        if (rx_ev)
        begin
          if (r.res_idx == `ASCD_RES_LAST)
          begin
            n.data_ready_n_n  = 1'b1; // R11
            n.res_idx = 2'h0;
            n.state   = ST_IDLE;
          end
          else
          begin
            n.res_idx = r.res_idx + 2'h1;
            n.tx      = res_byte(r.result, r.res_idx + 2'h1);
          end
        end
      end

      ST_WALK:
      begin
        if (walk_copy)
          n.ram[walk_ram] = r.regs[r.idx[3:0]]; // R20
        else if (walk_from)
          n.regs[r.idx[3:0]] = r.ram[walk_ram]; // R21
        else
          n.sum = r.sum + sum_byte; // R22
        if (r.idx == r.last)
        begin
          n.state = ST_IDLE;
          n.busy  = 1'b0; // R25
          if (!walk_copy && !walk_from)
            n.tx = n.sum;
        end
        else
          n.idx = r.idx + 7'h01;
      end
    endcase

    // A fresh result drops data-ready and restarts the byte count unless a single read is under way
    if (I_RESULT_VALID)
    begin
      n.result = I_RESULT;
      n.data_ready_n_n = 1'b0;
      if (n.state != ST_RESULT)
        n.res_idx = 2'h0;
    end

    if (n.cont && (n.state == ST_IDLE))
      n.tx = res_byte(n.result, n.res_idx); // R13
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RESET_N)
      r <= CORE_RST;
    else
      r <= n;
  end

  assign O_DATA_READY_N = r.data_ready_n_n;
  assign O_BUSY         = r.busy;
  assign O_CAL_START    = r.ctl.cal_start;
  assign O_CAL_KIND     = r.ctl.cal_kind;
  assign O_CONV_SYNC    = r.ctl.conv_sync;
  assign O_SLEEP        = r.ctl.sleep;
  assign O_WAKE         = r.ctl.wake;
  assign O_REGS_RESET   = r.ctl.regs_reset;

endmodule : ascd_top
`default_nettype wire

/* testbench/ascd_top_properties.sv */
// Port checks of the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module ascd_checker
(
  // Clock and reset
  input wire logic       I_SYS_CLK,
  input wire logic       I_RESET_N,
  // Watched ports
  input wire logic       I_CS_N,
  input wire logic       I_RESULT_VALID,
  input wire logic       O_DATA_READY_N,
  input wire logic       O_BUSY,
  input wire logic       O_CAL_START,
  input wire logic [2:0] O_CAL_KIND,
  input wire logic       O_SLEEP,
  input wire logic       O_WAKE,
  input wire logic       O_REGS_RESET
);
  logic [7:0] busy_cnt;
  // Length of the running walk in system clocks
  always_ff @(posedge I_SYS_CLK)
    busy_cnt <= (O_BUSY && I_RESET_N) ? busy_cnt + 8'h01 : 8'h00;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  cal_kind_range_a:
    assert property (O_CAL_START |-> O_CAL_KIND <= 3'h4)
    else $error("calibration kind out of range");
  cal_kind_idle_a:
    assert property (!O_CAL_START |-> O_CAL_KIND == 3'h0)
    else $error("calibration kind without start");
  cal_ready_high_a:
    assert property (O_CAL_START |-> ##[0:1] O_DATA_READY_N)
    else $error("ready flag low at calibration start");
  result_ready_a:
    assert property (I_RESULT_VALID |=> !O_DATA_READY_N)
    else $error("ready flag not low after result");
  walk_length_a:
    assert property ($fell(O_BUSY) |->
      busy_cnt == 8'h10 || busy_cnt == 8'h80)
    else $error("walk length wrong");
  walk_quiet_a:
    assert property (O_BUSY |->
      !(O_CAL_START || O_SLEEP || O_WAKE || O_REGS_RESET))
    else $error("command acted during walk");
  pulse_excl_a:
    assert property ($onehot0({O_WAKE, O_SLEEP, O_REGS_RESET, O_CAL_START}))
    else $error("two command pulses at once");
  data_ready_n_hold_a:
    assert property (I_CS_N [*2] ##1 !O_DATA_READY_N |=> !O_DATA_READY_N)
    else $error("ready flag rose without a read");
  cover property ($fell(O_BUSY));
  cover property (O_CAL_START);
  cover property ($rose(O_DATA_READY_N));
endmodule : ascd_checker
bind ascd_top ascd_checker ascd_checker_i (.I_SYS_CLK(I_SYS_CLK),
  .I_RESET_N(I_RESET_N), .I_CS_N(I_CS_N), .I_RESULT_VALID(I_RESULT_VALID),
  .O_DATA_READY_N(O_DATA_READY_N), .O_BUSY(O_BUSY),
  .O_CAL_START(O_CAL_START), .O_CAL_KIND(O_CAL_KIND), .O_SLEEP(O_SLEEP),
  .O_WAKE(O_WAKE), .O_REGS_RESET(O_REGS_RESET));
`default_nettype wire

/* testbench/ascd_host_model.sv */
// Host side of the serial link: frames and byte transfers
`timescale 1ns/1ps
`default_nettype none
module ascd_host_model
(
  // Serial lines
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_din,
  input  wire logic i_dout
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_din  = 1'b0;
    // Rising select at start clears the link frame counter
    #1 o_cs_n = 1'b1;
  end
  // Chip select stays low over a whole command sequence
  task automatic frame(input logic lo);
    #40 o_cs_n = ~lo;
    #40;
  endtask : frame
  // One byte MSB first; clock idles low, answer sampled on falling edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int k = 7; k >= 0; k--)
    begin
      o_din = tx[k];
      #6 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
      rx[k] = i_dout;
    end
    o_din = ~o_din;
    #250;
  endtask : xfer
endmodule : ascd_host_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] NOP = 8'h02;
  logic        clk = 1'b0;
  logic        rst_n = 1'b1;
  logic        res_vld = 1'b0;
  logic [23:0] res = 24'h00_0000;
  logic        sclk, cs_n, din, dout, data_ready_n_n, busy, cal_st, sync;
  logic        slp, wake, rreset;
  logic [2:0]  cal_kind;
  logic [4:0]  seen = 5'h00;
  logic [2:0]  kind = 3'h0;
  logic [7:0]  rx;
  logic [7:0]  regs [16] = '{default: 8'h00};
  logic [7:0]  ram [128] = '{default: 8'h00};
  int          err_total = 0;
  int          num_checks = 0;
  ascd_top ascd_top_i (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_DIN(din), .O_DOUT(dout), .I_RESULT_VALID(res_vld),
    .I_RESULT(res), .O_DATA_READY_N(data_ready_n_n), .O_BUSY(busy),
    .O_CAL_START(cal_st), .O_CAL_KIND(cal_kind), .O_CONV_SYNC(sync),
    .O_SLEEP(slp), .O_WAKE(wake), .O_REGS_RESET(rreset));
  ascd_host_model ascd_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din), .i_dout(dout));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    seen <= seen | {wake, slp, rreset, cal_st, sync};
    if (cal_st)
      kind <= cal_kind;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic x(input logic [7:0] b);
    ascd_host_model_i.xfer(b, rx);
  endtask : x
  task automatic fr(input logic lo);
    ascd_host_model_i.frame(lo);
  endtask : fr
  task automatic cmd(input logic [7:0] op);
    fr(1'b1);
    x(op);
    fr(1'b0);
  endtask : cmd
  task automatic pulse(input logic [23:0] v);
    @(negedge clk);
    res = v;
    res_vld = 1'b1;
    @(negedge clk);
    res_vld = 1'b0;
    @(negedge clk);
    chk("ready low", 8'h00, {7'h0, data_ready_n_n});
  endtask : pulse
  task automatic wr_seq(input logic [7:0] op, n, v0);
    logic [7:0] v;
    fr(1'b1);
    x(op);
    x(n);
    for (int i = 0; i <= int'(n); i++)
    begin
      v = v0 + 8'(i);
      x(v);
      if (op[5])
        ram[7'({op[2:0], 4'h0} + i)] = v;
      else
        regs[4'(op[3:0] + i)] = v;
    end
    fr(1'b0);
  endtask : wr_seq
  task automatic rd_seq(input logic [7:0] op, n);
    fr(1'b1);
    x(op);
    x(n);
    for (int i = 0; i <= int'(n); i++)
    begin
      x(NOP);
      chk("read byte", op[5] ? ram[7'({op[2:0], 4'h0} + i)]
        : regs[4'(op[3:0] + i)], rx);
    end
    fr(1'b0);
  endtask : rd_seq
  // Starts a copy or sum and waits for it; the frame stays open
  task automatic walk(input logic [7:0] op);
    fr(1'b1);
    x(op);
    chk("busy in walk", 8'h01, {7'h0, busy});
    for (int n = 0; n < 200 && busy === 1'b1; n++)
      @(negedge clk);
    chk("busy after walk", 8'h00, {7'h0, busy});
  endtask : walk
  // Masked sums leave out offset 0 bits 7:4 and 0, and all of offset 7
  function automatic logic [7:0] sum_of(input logic [7:0] op);
    logic [7:0] s;
    logic [7:0] b;
    s = 8'h00;
    for (int i = 0; i < 128; i++)
    begin
      b = (op == 8'hDF) ? regs[i % 16] : ram[i];
      if (op[7:4] == 4'hD && i % 16 == 0)
        b = b & 8'h0E;
      if (op[7:4] == 4'hD && i % 16 == 7)
        b = 8'h00;
      if (op == 8'hDF ? i < 16 : (op[3] || i / 16 == int'(op[2:0])))
        s = s + b;
    end
    return s;
  endfunction : sum_of
  task automatic t_ops;
    logic [7:0] ops [11] = '{8'h00, 8'hFF, 8'hFD, 8'hFE, 8'hF0, 8'hF1,
      8'hF2, 8'hF3, 8'hF4, 8'h30, 8'hFC};
    foreach (ops[i])
    begin
      @(negedge clk);
      seen = 5'h00;
      cmd(ops[i]);
      chk("pulses", {3'h0, ops[i] == 8'h00 || ops[i] == 8'hFF,
        ops[i] == 8'hFD, ops[i] == 8'hFE, ops[i] >= 8'hF0 &&
        ops[i] <= 8'hF4, 1'b0}, {3'h0, seen});
      if (ops[i][7:3] == 5'h1E)
        chk("cal kind", {5'h0, ops[i][2:0]}, {5'h0, kind});
    end
    seen = 5'h00;
    cmd(8'h00);
    chk("sync", 8'h11, {3'h0, seen});
    $display("test ops done");
  endtask : t_ops
  task automatic t_read;
    pulse(24'hA5_C3E1);
    fr(1'b1);
    x(8'h01);
    for (int k = 2; k >= 0; k--)
    begin
      x(NOP);
      chk("result byte", res[8*k +: 8], rx);
      if (k == 1)
        chk("ready partial", 8'h00, {7'h0, data_ready_n_n});
    end
    fr(1'b0);
    chk("ready after read", 8'h01, {7'h0, data_ready_n_n});
    $display("test read done");
  endtask : t_read
  task automatic t_regs;
    wr_seq(8'h5E, 8'h02, 8'hA1);
    rd_seq(8'h1E, 8'h02);
    rd_seq(8'h1F, 8'h0F);
    wr_seq(8'h67, 8'h11, 8'h40);
    rd_seq(8'h27, 8'h11);
    $display("test regs and banks done");
  endtask : t_regs
  task automatic t_walks;
    logic [7:0] sums [5] = '{8'hE7, 8'hD7, 8'hE8, 8'hD8, 8'hDF};
    walk(8'h41);
    fr(1'b0);
    for (int i = 0; i < 16; i++)
      ram[16 + i] = regs[i];
    rd_seq(8'h21, 8'h0F);
    walk(8'hC7);
    fr(1'b0);
    for (int i = 0; i < 16; i++)
      regs[i] = ram[112 + i];
    rd_seq(8'h10, 8'h0F);
    foreach (sums[i])
    begin
      walk(sums[i]);
      x(NOP);
      chk("checksum", sum_of(sums[i]), rx);
      fr(1'b0);
    end
    walk(8'h48);
    fr(1'b0);
    for (int i = 0; i < 128; i++)
      ram[i] = regs[i % 16];
    rd_seq(8'h23, 8'h0F);
    $display("test walks done");
  endtask : t_walks
  task automatic t_cont;
    cmd(8'h03);
    for (int r = 0; r < 2; r++)
    begin
      pulse(24'h3C_5A96 + 24'(r));
      fr(1'b1);
      for (int k = 2; k >= 0; k--)
      begin
        x((r == 1 && k == 1) ? 8'h0F : NOP);
        if (r == 0 || k == 2)
          chk("stream byte", res[8*k +: 8], rx);
      end
      fr(1'b0);
      if (r == 0)
        chk("ready after stream", 8'h01, {7'h0, data_ready_n_n});
    end
    wr_seq(8'h50, 8'h00, 8'h77);
    rd_seq(8'h10, 8'h00);
    cmd(8'h03);
    pulse(24'h00_0001);
    cmd(8'hFE);
    regs = '{default: 8'h00};
    rd_seq(8'h10, 8'h00);
    $display("test stream done");
  endtask : t_cont
  initial
  begin
    // A real falling edge clears the link-side toggles
    #1 rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_ops;
    t_read;
    t_regs;
    t_walks;
    t_cont;
    end_sim;
  end
  initial
  begin
    #400us;
    err_total++;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
